// ==== logic/serial_cfg_defs.svh ====
// constants for the eight-channel serial line configuration block
`ifndef SERIAL_CFG_DEFS_SVH
`define SERIAL_CFG_DEFS_SVH

// clock rate and receiver oversampling
`define MCLK_HZ 10000000
`define OVERSAMPLE 16
`define MID_BIT 4'h7
`define LAST_PHASE 4'hf

// address map: fixed top bits of the window, console block at octal 177560
`define ADDR_FIXED 3'h7
`define CONSOLE_ADDR 16'hff70
// console vector, octal 060
`define CONSOLE_VEC 9'h030

// register selectors within a channel
`define REG_RECEIVE_CONTROL_STATUS_REG 2'h0
`define REG_RECEIVE_BUFFER_REG 2'h1
`define REG_TRANSMIT_CONTROL_STATUS_REG 2'h2
`define REG_TRANSMIT_BUFFER_REG 2'h3

// bit positions
`define CSR_READY 7
`define CSR_IE 6
`define TRANSMIT_CONTROL_STATUS_REG_BREAK 0
`define TRANSMIT_CONTROL_STATUS_REG_BAUD_EN 11
`define TRANSMIT_CONTROL_STATUS_REG_CODE_LSB 12
`define RECEIVE_BUFFER_REG_ERR 15
`define RECEIVE_BUFFER_REG_OVR 14
`define RECEIVE_BUFFER_REG_FRM 13
`define RECEIVE_BUFFER_REG_PAR 12

// reset values
`define BAUD_RESET_CODE 4'he

`endif

// ==== logic/serial_cfg_pkg.sv ====
// types for the eight-channel serial line configuration block
package serial_cfg_pkg;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10
	} rx_state_e;

	typedef struct packed {
		logic req;
		logic write;
		logic [15:0] addr;
		logic [15:0] wdata;
	} bus_req_s;

	typedef struct packed {
		logic ack;
		logic hit;
		logic [15:0] rdata;
	} bus_rsp_s;

	typedef struct packed {
		logic consoleOn;
		logic [6:0] addrSw;
		logic [2:0] vecSw;
		logic [7:0] bfSw;
		logic [7:0] rxd;
	} pin_s;

	typedef struct packed {
		logic eight;
		logic parEn;
		logic parOdd;
		logic twoStop;
	} frame_s;

	typedef struct packed {
		logic hit;
		logic [2:0] ch;
		logic [1:0] sel;
	} decode_s;

	typedef struct packed {
		pin_s sync1;
		pin_s sync2;
		logic progEn;
		logic [3:0] progCode;
		logic [3:0] activeCode;
		logic [15:0] tickCnt;
		rx_state_e [7:0] rxSt;
		logic [7:0][3:0] rxPh;
		logic [7:0][3:0] rxCnt;
		logic [7:0][9:0] rxSh;
		logic [7:0][7:0] rxData;
		logic [7:0] rxDone;
		logic [7:0] rxIe;
		logic [7:0] ovr;
		logic [7:0] frm;
		logic [7:0] parErr;
		logic [7:0] txBusy;
		logic [7:0][3:0] txPh;
		logic [7:0][3:0] txCnt;
		logic [7:0][11:0] txSh;
		logic [7:0] txIe;
		logic [7:0] txBrk;
		logic [7:0] txLine;
		bus_rsp_s rsp;
		logic [8:0] vector;
	} state_s;

endpackage

// ==== logic/multichannel_serial_config.sv ====
// eight-channel serial line interface: decode, vectors, shared baud and framing, channels
`timescale 1ns/1ps
`include "serial_cfg_defs.svh"

// Overview of operation
// - base address from switches, octal 160000-177700
// - channels contiguous; console puts channel 7 at 177560
// - base vector from switches, octal 000-700
// - vectors contiguous; console channel 7 uses 60
// - vector switches 4,3,2 give bits 8,7,6
// - one baud code for all eight channels
// - codes 0-15 map to 50 through 19.2K
// - programmed code overrides switches when enabled
// - shared framing, always exactly one start bit
// - switch 4 selects seven or eight data bits
// - switch 3 enables or disables parity
// - switch 2 selects odd or even parity
// - switch 1 selects one or two stops
// - four word registers per channel, 32 total
// - data right-justified, bit 7 zero when seven-bit
// - parity error stays zero with parity disabled
module multichannel_serial_config
	import serial_cfg_pkg::*;
(
	// clock, reset, enable
	input wire logic mclk,
	input wire logic resetn,
	input wire logic clkEn,
	// switch banks, off reads 1
	input wire logic [6:0] addressSwitchBank,
	input wire logic consoleSwitch,
	input wire logic [4:2] vectorSwitchBank,
	input wire logic [8:1] baudFramingSwitchBank,
	// host register access
	input wire bus_req_s busIn,
	output bus_rsp_s busOut,
	// interrupt requests and vector lookup
	input wire logic [2:0] intChan,
	input wire logic intTx,
	output logic [8:0] intVector,
	output logic [7:0] rxIrq,
	output logic [7:0] txIrq,
	// serial lines
	input wire logic [7:0] serialIn,
	output logic [7:0] serialOut,
	// shared baud code in use
	output logic [3:0] activeBaudCode
);

	state_s r;
	state_s n;
	frame_s fr;
	decode_s dec;
	logic [3:0] swCode;
	logic [3:0] effCode;
	logic tick;
	logic allIdle;

	function automatic decode_s decodeAddr(input logic [15:0] a, input logic [6:0] sw,
		input logic con);
		decode_s d;
		d.hit = 1'b0;
		d.ch = a[5:3];
		d.sel = a[2:1];
		if (con && a[15:3] == 13'(`CONSOLE_ADDR >> 3)) begin
			d.hit = 1'b1;
			d.ch = 3'h7;
		end else if (a[15:13] == `ADDR_FIXED && a[12:6] == sw) begin
			d.hit = !(con && a[5:3] == 3'h7);
		end
		return d;
	endfunction

	// oversample divisor per baud code
	function automatic logic [15:0] baudDivisor(input logic [3:0] code);
		logic [15:0] dv;
		dv = 16'h1;
		unique case (code)
			4'h0: dv = 16'(`MCLK_HZ / (`OVERSAMPLE * 50));
			4'h1: dv = 16'(`MCLK_HZ / (`OVERSAMPLE * 75));
			4'h2: dv = 16'(`MCLK_HZ / (`OVERSAMPLE * 110));
			4'h3: dv = 16'((`MCLK_HZ * 2) / (`OVERSAMPLE * 269));
			4'h4: dv = 16'(`MCLK_HZ / (`OVERSAMPLE * 150));
			4'h5: dv = 16'(`MCLK_HZ / (`OVERSAMPLE * 200));
			4'h6: dv = 16'(`MCLK_HZ / (`OVERSAMPLE * 300));
			4'h7: dv = 16'(`MCLK_HZ / (`OVERSAMPLE * 600));
			4'h8: dv = 16'(`MCLK_HZ / (`OVERSAMPLE * 1200));
			4'h9: dv = 16'(`MCLK_HZ / (`OVERSAMPLE * 1800));
			4'ha: dv = 16'(`MCLK_HZ / (`OVERSAMPLE * 2400));
			4'hb: dv = 16'(`MCLK_HZ / (`OVERSAMPLE * 3600));
			4'hc: dv = 16'(`MCLK_HZ / (`OVERSAMPLE * 4800));
			4'hd: dv = 16'(`MCLK_HZ / (`OVERSAMPLE * 7200));
			4'he: dv = 16'(`MCLK_HZ / (`OVERSAMPLE * 9600));
			4'hf: dv = 16'(`MCLK_HZ / (`OVERSAMPLE * 19200));
		endcase
		return dv;
	endfunction

	// shared framing from switch positions 1-4
	assign fr.eight = r.sync2.bfSw[3];
	assign fr.parEn = r.sync2.bfSw[2];
	assign fr.parOdd = !r.sync2.bfSw[1];
	assign fr.twoStop = r.sync2.bfSw[0];
	assign swCode = {r.sync2.bfSw[4], r.sync2.bfSw[5], r.sync2.bfSw[6], r.sync2.bfSw[7]};
	assign effCode = r.progEn ? r.progCode : swCode;
	assign tick = r.tickCnt == 16'h0;
	assign dec = decodeAddr(busIn.addr, r.sync2.addrSw, r.sync2.consoleOn);

	always_comb begin
		allIdle = 1'b1;
		for (int c = 0; c < 8; c++) begin
			if (r.rxSt[c] != RX_IDLE || r.txBusy[c]) begin
				allIdle = 1'b0;
			end
		end
	end

	always_comb begin
		logic [11:0] w;
		logic [9:0] v;
		logic [9:0] s;
		logic [7:0] d;
		logic [3:0] dl;
		logic [3:0] nb;
		logic line;
		logic [9:0] pm;
		w = '1;
		v = '0;
		s = '0;
		d = '0;
		dl = fr.eight ? 4'h8 : 4'h7;
		nb = 4'(dl + {3'h0, fr.parEn} + 4'h1);
		line = 1'b1;
		// mask of data plus parity positions, kept constant-width for the parity check
		pm = 10'((11'h2 << dl) - 11'h1);
		n = r;
		n.sync1 = '{consoleSwitch, addressSwitchBank, vectorSwitchBank,
			baudFramingSwitchBank, serialIn};
		n.sync2 = r.sync1;
		n.rsp.ack = 1'b0;
		n.rsp.hit = 1'b0;
		// reads; reading the receive buffer clears done
		if (busIn.req) begin
			n.rsp.ack = 1'b1;
			n.rsp.hit = dec.hit;
			n.rsp.rdata = '0;
			if (dec.hit && !busIn.write) begin
				unique case (dec.sel)
					`REG_RECEIVE_CONTROL_STATUS_REG: begin
						n.rsp.rdata[`CSR_READY] = r.rxDone[dec.ch];
						n.rsp.rdata[`CSR_IE] = r.rxIe[dec.ch];
					end
					`REG_RECEIVE_BUFFER_REG: begin
						n.rsp.rdata[`RECEIVE_BUFFER_REG_OVR] = r.ovr[dec.ch];
						n.rsp.rdata[`RECEIVE_BUFFER_REG_FRM] = r.frm[dec.ch];
						n.rsp.rdata[`RECEIVE_BUFFER_REG_PAR] = r.parErr[dec.ch];
						n.rsp.rdata[`RECEIVE_BUFFER_REG_ERR] = r.ovr[dec.ch] | r.frm[dec.ch] | r.parErr[dec.ch];
						n.rsp.rdata[7:0] = r.rxData[dec.ch];
						n.rsp.rdata[7] = r.rxData[dec.ch][7] & fr.eight;
						n.rxDone[dec.ch] = 1'b0;
					end
					`REG_TRANSMIT_CONTROL_STATUS_REG: begin
						n.rsp.rdata[`CSR_READY] = !r.txBusy[dec.ch];
						n.rsp.rdata[`CSR_IE] = r.txIe[dec.ch];
						n.rsp.rdata[`TRANSMIT_CONTROL_STATUS_REG_BREAK] = r.txBrk[dec.ch];
					end
					`REG_TRANSMIT_BUFFER_REG: n.rsp.rdata = '0;
				endcase
			end
		end
		for (int c = 0; c < 8; c++) begin
			line = r.sync2.rxd[c];
			unique case (r.rxSt[c])
				RX_IDLE: if (tick && !line) begin
					n.rxSt[c] = RX_START;
					n.rxPh[c] = 4'h0;
				end
				RX_START: if (tick) begin
					n.rxPh[c] = 4'(r.rxPh[c] + 4'h1);
					if (r.rxPh[c] == `MID_BIT) begin
						n.rxSt[c] = line ? RX_IDLE : RX_DATA;
						n.rxPh[c] = 4'h0;
						n.rxCnt[c] = nb;
					end
				end
				RX_DATA: if (tick) begin
					n.rxPh[c] = 4'(r.rxPh[c] + 4'h1);
					if (r.rxPh[c] == `LAST_PHASE) begin
						s = {line, r.rxSh[c][9:1]};
						n.rxSh[c] = s;
						n.rxCnt[c] = 4'(r.rxCnt[c] - 4'h1);
						if (r.rxCnt[c] == 4'h1) begin
							v = '0;
							for (int i = 0; i < 10; i++) begin
								if (i < int'(nb)) begin
									v[i] = s[i + 10 - int'(nb)];
								end
							end
							d = v[7:0];
							d[7] = d[7] & fr.eight;
							n.rxData[c] = d;
							n.parErr[c] = fr.parEn && ((^(v & pm)) != fr.parOdd);
							n.frm[c] = !v[4'(dl + {3'h0, fr.parEn})];
							n.ovr[c] = n.rxDone[c];
							n.rxDone[c] = 1'b1;
							n.rxSt[c] = RX_IDLE;
						end
					end
				end
				default: n.rxSt[c] = RX_IDLE;
			endcase
			if (r.txBusy[c] && tick) begin
				n.txPh[c] = 4'(r.txPh[c] + 4'h1);
				if (r.txPh[c] == `LAST_PHASE) begin
					n.txSh[c] = {1'b1, r.txSh[c][11:1]};
					n.txCnt[c] = 4'(r.txCnt[c] - 4'h1);
					n.txBusy[c] = r.txCnt[c] != 4'h1;
				end
			end
		end
		if (!fr.parEn) begin
			n.parErr = '0;
		end
		// writes
		if (busIn.req && busIn.write && dec.hit) begin
			unique case (dec.sel)
				`REG_RECEIVE_CONTROL_STATUS_REG: n.rxIe[dec.ch] = busIn.wdata[`CSR_IE];
				`REG_RECEIVE_BUFFER_REG: n.rxIe[dec.ch] = r.rxIe[dec.ch];
				`REG_TRANSMIT_CONTROL_STATUS_REG: begin
					n.txIe[dec.ch] = busIn.wdata[`CSR_IE];
					n.txBrk[dec.ch] = busIn.wdata[`TRANSMIT_CONTROL_STATUS_REG_BREAK];
					n.progEn = busIn.wdata[`TRANSMIT_CONTROL_STATUS_REG_BAUD_EN];
					n.progCode = busIn.wdata[`TRANSMIT_CONTROL_STATUS_REG_CODE_LSB+:4];
				end
				`REG_TRANSMIT_BUFFER_REG: if (!r.txBusy[dec.ch]) begin
					d = busIn.wdata[7:0];
					d[7] = d[7] & fr.eight;
					w = '1;
					w[0] = 1'b0;
					for (int i = 0; i < 8; i++) begin
						if (i < int'(dl)) begin
							w[i + 1] = d[i];
						end
					end
					if (fr.parEn) begin
						w[4'(dl + 4'h1)] = (^d) ^ fr.parOdd;
					end
					n.txSh[dec.ch] = w;
					n.txCnt[dec.ch] = 4'(nb + 4'h1 + {3'h0, fr.twoStop});
					n.txPh[dec.ch] = 4'h0;
					n.txBusy[dec.ch] = 1'b1;
				end
			endcase
		end
		for (int c = 0; c < 8; c++) begin
			n.txLine[c] = (n.txBusy[c] ? n.txSh[c][0] : 1'b1) & !n.txBrk[c];
		end
		// shared bit clock; a new code waits until every channel is idle
		if (allIdle && r.activeCode != effCode) begin
			n.activeCode = effCode;
			n.tickCnt = 16'h0;
		end else begin
			n.tickCnt = tick ? 16'(baudDivisor(r.activeCode) - 16'h1) : 16'(r.tickCnt - 16'h1);
		end
		if (r.sync2.consoleOn && intChan == 3'h7) begin
			n.vector = `CONSOLE_VEC | {6'h0, intTx, 2'h0};
		end else begin
			n.vector = {r.sync2.vecSw, intChan, intTx, 2'h0};
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			r <= '0;
			r.sync1 <= '1;
			r.sync2 <= '1;
			r.activeCode <= `BAUD_RESET_CODE;
			r.txLine <= '1;
		end else if (clkEn) begin
			r <= n;
		end
	end

	assign busOut = r.rsp;
	assign intVector = r.vector;
	assign rxIrq = r.rxDone & r.rxIe;
	assign txIrq = ~r.txBusy & r.txIe;
	assign serialOut = r.txLine;
	assign activeBaudCode = r.activeCode;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	sequence rbufRead;
		clkEn && busIn.req && !busIn.write && dec.hit && dec.sel == `REG_RECEIVE_BUFFER_REG;
	endsequence
	sequence xcsrWrite;
		clkEn && busIn.req && busIn.write && dec.hit && dec.sel == `REG_TRANSMIT_CONTROL_STATUS_REG;
	endsequence
	sequence txLaunch;
		clkEn && busIn.req && busIn.write && dec.hit && dec.sel == `REG_TRANSMIT_BUFFER_REG &&
			!r.txBusy[dec.ch];
	endsequence

	a_addr_range: assert property (clkEn && busIn.req && busIn.addr[15:13] != 3'h7
		|=> busOut.ack && !busOut.hit) else $error("address outside window decoded");
	a_console_remap: assert property (clkEn && busIn.req && r.sync2.consoleOn &&
		busIn.addr[15:3] == 13'h1fee |-> dec.ch == 3'h7 ##1 busOut.hit)
		else $error("console address not mapped to channel 7");
	a_vector_layout: assert property (clkEn && !(r.sync2.consoleOn && intChan == 3'h7)
		|=> intVector == {$past(r.sync2.vecSw), $past(intChan), $past(intTx), 2'h0})
		else $error("contiguous vector wrong");
	a_vector_console: assert property (clkEn && r.sync2.consoleOn && intChan == 3'h7
		|=> intVector == (9'h030 | {6'h0, $past(intTx), 2'h0}))
		else $error("console vector wrong");
	a_baud_override: assert property (xcsrWrite and busIn.wdata[11]
		|=> effCode == $past(busIn.wdata[15:12])) else $error("programmed baud not used");
	a_baud_switch: assert property (xcsrWrite and !busIn.wdata[11]
		|=> effCode == swCode) else $error("switch baud not used");
	a_rate_boundary: assert property (clkEn && !allIdle |=> $stable(r.activeCode))
		else $error("baud changed mid character");
	a_parity_off: assert property (clkEn && !fr.parEn |=> r.parErr == 8'h0)
		else $error("parity error set with parity off");
	a_seven_bit: assert property (rbufRead and !fr.eight |=> !busOut.rdata[7])
		else $error("bit 7 set in seven-bit mode");
	a_start_bit: assert property (txLaunch |=> !serialOut[$past(dec.ch)])
		else $error("no start bit after load");

endmodule

// ==== tb/serial_host_model.sv ====
// host processor model: one-cycle register requests, answer taken on ack
`timescale 1ns/1ps
module serial_host_model
	import serial_cfg_pkg::*;
(
	// clock
	input wire logic mclk,
	// register port
	input wire bus_rsp_s busOut,
	output bus_req_s busIn
);
	initial busIn = '0;

	task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] wd,
		output logic hit, output logic [15:0] rd, output logic ok);
		int n;
		ok = 1'b0;
		hit = 1'b0;
		rd = '0;
		@(posedge mclk);
		#1 busIn = '{req: 1'b1, write: wr, addr: a, wdata: wd};
		@(posedge mclk);
		// released lines no longer show the old request
		#1 busIn = '{req: 1'b0, write: ~wr, addr: ~a, wdata: ~wd};
		for (n = 0; n < 4; n++) begin
			if (busOut.ack === 1'b1) begin
				ok = 1'b1;
				hit = busOut.hit;
				rd = busOut.rdata;
				break;
			end
			@(posedge mclk);
			#1;
		end
	endtask
endmodule

// ==== tb/multichannel_serial_config_test.sv ====
// self-checking bench: decode, vectors, shared baud, framing over a loopback
`timescale 1ns/1ps
`include "serial_cfg_defs.svh"
module multichannel_serial_config_test
	import serial_cfg_pkg::*;
;
	logic mclk, resetn, clkEn, con, intTx, hit;
	logic [6:0] sw;
	logic [2:0] vecSw, intChan, ch;
	logic [8:1] bfSw;
	logic [3:0] code, pc, fr;
	logic [7:0] serialOut, rxIrq, txIrq, d;
	logic [8:0] intVector;
	logic [3:0] activeBaudCode;
	logic [15:0] rd;
	bus_req_s busIn;
	bus_rsp_s busOut;
	int mismatches, checked, seed, k, t, i;

	multichannel_serial_config i_multichannel_serial_config (.mclk(mclk), .resetn(resetn),
		.clkEn(clkEn), .addressSwitchBank(sw), .consoleSwitch(con), .vectorSwitchBank(vecSw),
		.baudFramingSwitchBank(bfSw), .busIn(busIn), .busOut(busOut), .intChan(intChan),
		.intTx(intTx), .intVector(intVector), .rxIrq(rxIrq), .txIrq(txIrq),
		.serialIn(serialOut), .serialOut(serialOut), .activeBaudCode(activeBaudCode));
	serial_host_model i_serial_host_model (.mclk(mclk), .busOut(busOut), .busIn(busIn));

	always #50 mclk = ~mclk;

	function automatic logic [15:0] f_addr(logic [6:0] s, logic [2:0] c, logic [1:0] r);
		return {3'h7, s, c, r, 1'b0};
	endfunction
	function automatic logic [8:0] f_vec(logic [2:0] v, logic [2:0] c, logic x, logic cn);
		return (cn && c == 3'h7) ? 9'h030 + {6'h0, x, 2'h0} : {v, c, x, 2'h0};
	endfunction

	task automatic final_report();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_vec(input logic [8:0] got, input logic [8:0] exp);
		cmp_word({7'h0, got}, {7'h0, exp});
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		cmp_word({15'h0, got}, {15'h0, exp});
	endtask
	task automatic bus(input logic wr, input logic [15:0] a, input logic [15:0] wd);
		logic ok;
		i_serial_host_model.access(wr, a, wd, hit, rd, ok);
		if (ok !== 1'b1) begin
			mismatches++;
			final_report();
		end
	endtask
	task automatic poll(input logic [15:0] a);
		int n;
		for (n = 0; n < 400; n++) begin
			bus(1'b0, a, 16'h0);
			if (rd[7] === 1'b1) return;
			repeat (30) @(posedge mclk);
		end
		mismatches++;
		final_report();
	endtask
	task automatic wait_code(input logic [3:0] exp);
		int n;
		for (n = 0; n < 40 && activeBaudCode !== exp; n++) @(posedge mclk);
		#1 cmp_word({12'h0, activeBaudCode}, {12'h0, exp});
		if (activeBaudCode !== exp) begin
			final_report();
		end
	endtask
	task automatic set_sw(input logic [3:0] c, input logic [3:0] f);
		@(posedge mclk);
		#1 bfSw = {c[0], c[1], c[2], c[3], f};
		repeat (4) @(posedge mclk);
	endtask

	initial begin
		seed = 32'hf500;
		mclk = 1'b0;
		resetn = 1'b0;
		clkEn = 1'b1;
		sw = 7'h7f;
		con = 1'b0;
		vecSw = 3'h3;
		bfSw = 8'hff;
		intChan = 3'h0;
		intTx = 1'b0;
		repeat (12) @(posedge mclk);
		cmp_word({12'h0, activeBaudCode}, 16'h000e);
		#1 resetn = 1'b1;
		repeat (4) @(posedge mclk);
		for (k = 0; k < 4; k++) begin
			#1 sw = (k == 0) ? 7'h00 : (k == 1) ? 7'h7f : 7'($random(seed));
			if (sw == 7'h7d) sw = 7'h00;
			con = k[0];
			vecSw = 3'($random(seed));
			repeat (4) @(posedge mclk);
			for (i = 0; i < 8; i++) begin
				bus(1'b0, f_addr(sw, 3'(i), `REG_TRANSMIT_CONTROL_STATUS_REG), 16'h0);
				cmp_bit(hit, !(con && i == 7));
				cmp_word(rd, (con && i == 7) ? 16'h0 : 16'h0080);
				for (t = 0; t < 2; t++) begin
					#1 intChan = 3'(i);
					intTx = t[0];
					@(posedge mclk);
					#1 cmp_vec(intVector, f_vec(vecSw, 3'(i), t[0], con));
				end
			end
			// enable low must freeze the vector register
			#1 clkEn = 1'b0;
			intChan = 3'h5;
			repeat (3) @(posedge mclk);
			#1 cmp_vec(intVector, f_vec(vecSw, 3'h7, 1'b1, con));
			clkEn = 1'b1;
			bus(1'b0, 16'hff74, 16'h0);
			cmp_word({hit, rd[14:0]}, con ? 16'h8080 : 16'h0);
			bus(1'b0, {3'h6, sw, 6'h0}, 16'h0);
			cmp_bit(hit, 1'b0);
		end
		#1 con = 1'b0;
		for (k = 0; k < 4; k++) begin
			code = (k == 0) ? 4'h0 : (k == 1) ? 4'hf : 4'($random(seed));
			pc = 4'($random(seed));
			set_sw(code, 4'hf);
			wait_code(code);
			bus(1'b1, f_addr(sw, 3'($random(seed)), `REG_TRANSMIT_CONTROL_STATUS_REG), {pc, 1'b1, 11'h0});
			wait_code(pc);
			bus(1'b1, f_addr(sw, 3'h0, `REG_TRANSMIT_CONTROL_STATUS_REG), 16'h0);
			wait_code(code);
		end
		for (k = 0; k < 6; k++) begin
			fr = (k < 4) ? 4'(1 << k) ^ 4'hf : 4'($random(seed));
			set_sw(4'hf, fr);
			ch = 3'($random(seed));
			d = 8'($random(seed)) | 8'h80;
			bus(1'b1, f_addr(sw, ch, `REG_RECEIVE_CONTROL_STATUS_REG), 16'h0040);
			bus(1'b1, f_addr(sw, ch, `REG_TRANSMIT_BUFFER_REG), {8'h0, d});
			cmp_bit(serialOut[ch], 1'b0);
			if (k == 0) begin
				bus(1'b1, f_addr(sw, ch, `REG_TRANSMIT_CONTROL_STATUS_REG), {4'hc, 1'b1, 4'h0, 1'b1, 6'h0});
				cmp_word({12'h0, activeBaudCode}, 16'h000f);
				cmp_bit(txIrq[ch], 1'b0);
			end
			poll(f_addr(sw, ch, `REG_TRANSMIT_CONTROL_STATUS_REG));
			if (k == 0) begin
				cmp_bit(txIrq[ch], 1'b1);
			end
			bus(1'b0, f_addr(sw, ch, `REG_RECEIVE_CONTROL_STATUS_REG), 16'h0);
			cmp_word(rd, 16'h00c0);
			cmp_bit(rxIrq[ch], 1'b1);
			bus(1'b0, f_addr(sw, ch, `REG_RECEIVE_BUFFER_REG), 16'h0);
			cmp_word(rd, {8'h0, fr[3] ? d : {1'b0, d[6:0]}});
			bus(1'b0, f_addr(sw, ch, `REG_RECEIVE_CONTROL_STATUS_REG), 16'h0);
			cmp_word(rd, 16'h0040);
			cmp_bit(rxIrq[ch], 1'b0);
			if (k == 0) begin
				wait_code(4'hc);
				bus(1'b1, f_addr(sw, ch, `REG_TRANSMIT_CONTROL_STATUS_REG), 16'h0);
				wait_code(4'hf);
			end
		end
		final_report();
	end
endmodule
